// file: verilog/hgcs_consts.vh
// Register offsets, field positions and reset values of the hub config bank
`ifndef HGCS_CONSTS_VH
`define HGCS_CONSTS_VH
`define HGCS_ADDR_W           8
`define HGCS_OFF_TOPCFG       8'h02
`define HGCS_OFF_SILVER       8'h03
`define HGCS_OFF_LINKSTS      8'h04
`define HGCS_OFF_PARHI        8'h05
`define HGCS_OFF_PARLO        8'h06
`define HGCS_BIT_I2CMEN       5
`define HGCS_BIT_OUTENMODE    4
`define HGCS_BIT_OUTEN        3
`define HGCS_BIT_IDLESEL      2
`define HGCS_BIT_PARCHKEN     1
`define HGCS_BIT_REFOVR       0
`define HGCS_TOPCFG_RST       8'h1e
`define HGCS_TOPCFG_WMASK     8'h3f
`define HGCS_BIT_SUMOK        7
`define HGCS_BIT_INITDONE     6
`define HGCS_BIT_REFINRANGE   4
`define HGCS_PARHI_RST        8'h01
`define HGCS_PARLO_RST        8'h00
`define HGCS_OUT_NORMAL       2'h0
`define HGCS_OUT_HIZ          2'h1
`define HGCS_OUT_LP11         2'h2
`define HGCS_OUT_HS0          2'h3
`define HGCS_REF_MIN_MHZ      12
`define HGCS_REF_MAX_MHZ      64
`define HGCS_CLK_MHZ          125
`define HGCS_REF_WIN_CYC      16'd1000
`endif

// file: verilog/hgcs_sync.v
// Three-flop input synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module hgcs_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         nrst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1Q;
  reg [W-1:0] s2Q;
  reg [W-1:0] s3Q;
  reg [W-1:0] outQ;
  genvar i;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1Q <= {W{1'b0}};
      s2Q <= {W{1'b0}};
      s3Q <= {W{1'b0}};
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          outQ[i] <= 1'b0;
        end else if (s2Q[i] == s3Q[i]) begin
          outQ[i] <= s3Q[i];
        end
      end
    end
  endgenerate
  assign dout = outQ;
endmodule // hgcs_sync
`default_nettype wire

// file: verilog/hgcs_par_counter.v
// Per-port parity error counter with threshold flag
`timescale 1ns/1ps
`default_nettype none
module hgcs_par_counter #(
  parameter CW = 16
) (
  input  wire          ref_clk,
  input  wire          nrst,
  input  wire          countEn,
  input  wire          parErr,
  input  wire          clearCnt,
  input  wire [CW-1:0] limit,
  output wire          errFlag
);
  reg [CW-1:0] cntQ;
  reg          flagQ;
  wire         sat = &cntQ;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cntQ  <= {CW{1'b0}};
      flagQ <= 1'b0;
    end else begin
      // Saturate rather than wrap, so the flag cannot fall back
      if (clearCnt) begin
        cntQ <= {CW{1'b0}};
      end else if (countEn && parErr && !sat) begin
        cntQ <= cntQ + {{(CW-1){1'b0}}, 1'b1};
      end
      // Counter and limit both compared; a new error holds the flag over the clear, but the clear still zeroes the counter
      flagQ <= (cntQ >= limit) && !(clearCnt && !(countEn && parErr));
    end
  end
  assign errFlag = flagQ;
endmodule // hgcs_par_counter
`default_nettype wire

// file: verilog/hgcs_top.v
// Shared configuration and status register bank of the deserializer hub
// Functional notes
// - Local I2C master enabled only while config bit 5 is set.
// - Mode bit 4 clear and no assigned port locked: output high impedance.
// - Mode bit 4 set, no lock: output follows its control, LP-11 with bits 3 and 2 set.
// - No lock, idle select 1, output enable 0: outputs high impedance.
// - No lock, mode bit 4 set, idle select 0: outputs driven to HS-0.
// - Parity checked only while bit 1 is set.
// - Override bit 0 forces reference clock reported present.
// - Revision register: step code bits 7:4, mask code bits 3:0.
// - Status bit 7 shows configuration checksum passed after init.
// - Status bit 6 shows power-up initialization complete.
// - Status bit 4 set while reference clock is 12 to 64 MHz.
// - Sixteen-bit limit: upper register bits 15:8, lower bits 7:0.
// - Per port flag set once parity errors reach the limit.
`timescale 1ns/1ps
`default_nettype none
`include "hgcs_consts.vh"
module hgcs_top #(
  parameter       NPORT     = 4,
  parameter [3:0] STEP_CODE = 4'h0, // Arbitrary value
  parameter [3:0] MASK_CODE = 4'h0  // Arbitrary value
) (
  input  wire                   ref_clk,
  input  wire                   nrst,
  input  wire [7:0]             regAddr,
  input  wire                   regWrite,
  input  wire                   regRead,
  input  wire [7:0]             regWdata,
  output wire [7:0]             regRdata,
  input  wire [NPORT-1:0]       portLock,
  input  wire [NPORT-1:0]       portAssigned,
  input  wire [NPORT-1:0]       portParErr,
  input  wire [NPORT-1:0]       portErrClear,
  output wire [NPORT-1:0]       portParFlag,
  input  wire                   referenceClockInput,
  input  wire                   configSumPassedIn,
  input  wire                   initDoneIn,
  output wire                   i2cMasterEn,
  output wire                   parityCheckEn,
  output wire [1:0]             cameraOutState,
  output wire                   refClockPresent
);
  reg  [7:0]  cfgQ;
  reg  [7:0]  parHiQ;
  reg  [7:0]  parLoQ;
  reg  [7:0]  rdataQ;
  reg  [15:0] winCntQ;
  reg  [15:0] edgeCntQ;
  reg         refPrevQ;
  reg         inRangeQ;
  reg  [7:0]  rdataD;
  reg  [1:0]  outStateD;
  wire [2:0]  syncOut;
  wire        refSync;
  wire        sumOk;
  wire        initDone;
  wire        anyLock;
  wire [15:0] parityLimitValue;
  wire        winEnd;
  // Edges per 1000 cycles at 125 MHz: 12 MHz -> 96, 64 MHz -> 512
  wire [31:0] minEdgesW = `HGCS_REF_MIN_MHZ * `HGCS_REF_WIN_CYC
                          / `HGCS_CLK_MHZ;
  wire [31:0] maxEdgesW = `HGCS_REF_MAX_MHZ * `HGCS_REF_WIN_CYC
                          / `HGCS_CLK_MHZ;
  wire [15:0] minEdges  = minEdgesW[15:0];
  wire [15:0] maxEdges  = maxEdgesW[15:0];
  genvar p;

  hgcs_sync #(
    .W (3)
  ) uSync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({referenceClockInput, configSumPassedIn, initDoneIn}),
    .dout    (syncOut)
  );
  assign refSync  = syncOut[2];
  assign sumOk    = syncOut[1];
  assign initDone = syncOut[0];

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfgQ   <= `HGCS_TOPCFG_RST;
      parHiQ <= `HGCS_PARHI_RST;
      parLoQ <= `HGCS_PARLO_RST;
    end else if (regWrite) begin
      case (regAddr)
        `HGCS_OFF_TOPCFG: cfgQ   <= regWdata & `HGCS_TOPCFG_WMASK;
        `HGCS_OFF_PARHI:  parHiQ <= regWdata;
        `HGCS_OFF_PARLO:  parLoQ <= regWdata;
        default:          cfgQ   <= cfgQ;
      endcase
    end
  end

  assign parityLimitValue = {parHiQ, parLoQ};

  // Sampled reference clock is only a coarse measure; fast clocks alias
  assign winEnd = (winCntQ == `HGCS_REF_WIN_CYC - 16'd1);
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      winCntQ  <= 16'h0000;
      edgeCntQ <= 16'h0000;
      refPrevQ <= 1'b0;
      inRangeQ <= 1'b0;
    end else begin
      refPrevQ <= refSync;
      winCntQ  <= winEnd ? 16'h0000 : winCntQ + 16'h0001;
      if (winEnd) begin
        edgeCntQ <= 16'h0000;
        inRangeQ <= (edgeCntQ >= minEdges) && (edgeCntQ <= maxEdges);
      end else if (refSync && !refPrevQ && !(&edgeCntQ)) begin
        edgeCntQ <= edgeCntQ + 16'h0001;
      end
    end
  end

  assign refClockPresent = cfgQ[`HGCS_BIT_REFOVR] | inRangeQ;
  assign i2cMasterEn     = cfgQ[`HGCS_BIT_I2CMEN];
  assign parityCheckEn   = cfgQ[`HGCS_BIT_PARCHKEN];
  assign anyLock         = |(portLock & portAssigned);

  always @* begin
    outStateD = `HGCS_OUT_NORMAL;
    if (!anyLock) begin
      if (!cfgQ[`HGCS_BIT_OUTENMODE]) begin
        outStateD = `HGCS_OUT_HIZ;
      end else if (!cfgQ[`HGCS_BIT_IDLESEL]) begin
        outStateD = `HGCS_OUT_HS0;
      end else if (!cfgQ[`HGCS_BIT_OUTEN]) begin
        outStateD = `HGCS_OUT_HIZ;
      end else begin
        outStateD = `HGCS_OUT_LP11;
      end
    end
  end
  assign cameraOutState = outStateD;

  generate
    for (p = 0; p < NPORT; p = p + 1) begin : gPort
      hgcs_par_counter #(
        .CW (16)
      ) uCnt (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .countEn  (cfgQ[`HGCS_BIT_PARCHKEN]),
        .parErr   (portParErr[p]),
        .clearCnt (portErrClear[p]),
        .limit    (parityLimitValue),
        .errFlag  (portParFlag[p])
      );
    end
  endgenerate

  always @* begin
    rdataD = 8'h00;
    case (regAddr)
      `HGCS_OFF_TOPCFG: rdataD = cfgQ;
      `HGCS_OFF_SILVER: rdataD = {STEP_CODE, MASK_CODE};
      `HGCS_OFF_LINKSTS: begin
        rdataD[`HGCS_BIT_SUMOK]      = sumOk && initDone;
        rdataD[`HGCS_BIT_INITDONE]   = initDone;
        rdataD[`HGCS_BIT_REFINRANGE] = inRangeQ;
      end
      `HGCS_OFF_PARHI:  rdataD = parHiQ;
      `HGCS_OFF_PARLO:  rdataD = parLoQ;
      default:          rdataD = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdataQ <= 8'h00;
    end else if (regRead) begin
      rdataQ <= rdataD;
    end
  end
  assign regRdata = rdataQ;
endmodule // hgcs_top
`default_nettype wire

// file: testbench/hgcs_checker.sv
// Port-level assertions for the hub configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "hgcs_consts.vh"
module hgcs_checker #(
  parameter       NPORT     = 4,
  parameter [3:0] STEP_CODE = 4'h0,
  parameter [3:0] MASK_CODE = 4'h0
) (
  input wire             ref_clk,
  input wire             nrst,
  input wire [7:0]       regAddr,
  input wire             regWrite,
  input wire             regRead,
  input wire [7:0]       regWdata,
  input wire [7:0]       regRdata,
  input wire [NPORT-1:0] portLock,
  input wire [NPORT-1:0] portAssigned,
  input wire             i2cMasterEn,
  input wire             parityCheckEn,
  input wire [1:0]       cameraOutState,
  input wire             refClockPresent
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Shadow config byte, so output rules can be judged from ports alone
  reg  [7:0] cfgQ;
  wire       cfgWr  = regWrite && regAddr == `HGCS_OFF_TOPCFG;
  wire       noLock = (portLock & portAssigned) == 0;
  always @(posedge ref_clk or negedge nrst)
    if (!nrst) cfgQ <= `HGCS_TOPCFG_RST;
    else if (cfgWr) cfgQ <= regWdata;
  i2c_en_a: assert property (cfgWr |=> i2cMasterEn == $past(regWdata[5]))
    else $error("master enable not following config bit 5");
  out_hiz_a: assert property (noLock && !cfgQ[4] |-> cameraOutState == 2'h1)
    else $error("output not high impedance in mode 0");
  out_lp11_a: assert property (noLock && cfgQ[4] && cfgQ[3] && cfgQ[2]
    |-> cameraOutState == 2'h2) else $error("output not in LP-11");
  sleep_hiz_a: assert property (noLock && cfgQ[4] && cfgQ[2] && !cfgQ[3]
    |-> cameraOutState == 2'h1) else $error("output not high impedance");
  out_hs0_a: assert property (noLock && cfgQ[4] && !cfgQ[2] |-> cameraOutState == 2'h3)
    else $error("output not in HS-0");
  locked_run_a: assert property (!noLock |-> cameraOutState == 2'h0)
    else $error("output not normal while a port is locked");
  par_en_a: assert property (cfgWr |=> parityCheckEn == $past(regWdata[1]))
    else $error("parity enable not following config bit 1");
  ref_ovr_a: assert property (cfgQ[0] |-> refClockPresent)
    else $error("override did not report reference present");
  rev_read_a: assert property (regRead && regAddr == `HGCS_OFF_SILVER
    |=> regRdata == {STEP_CODE, MASK_CODE}) else $error("bad revision byte");
  cover property (noLock && cfgQ[4] && !cfgQ[2]);
  cover property (cfgWr ##1 regRead);
  cover property (cfgQ[0] && refClockPresent);
endmodule // hgcs_checker
bind hgcs_top hgcs_checker #(.NPORT(NPORT), .STEP_CODE(STEP_CODE),
  .MASK_CODE(MASK_CODE)) i_hgcs_checker (.ref_clk, .nrst, .regAddr,
  .regWrite, .regRead, .regWdata, .regRdata, .portLock, .portAssigned,
  .i2cMasterEn, .parityCheckEn, .cameraOutState, .refClockPresent);
`default_nettype wire

// file: testbench/hgcs_top_bench.sv
// Self-checking bench for the hub configuration bank
`timescale 1ns/1ps
`default_nettype none
module hgcs_top_bench;
  reg         ref_clk = 0, nrst = 0, regWrite = 0, regRead = 0, rdLate = 0;
  reg  [7:0]  regAddr = 0, regWdata = 0, v;
  reg  [3:0]  portLock = 0, portAssigned = 0, portParErr = 0, portErrClear = 0;
  reg         refIn = 0, refRun = 1, sumOk = 1, initDone = 1;
  reg  [1:0]  st;
  reg  [7:0]  expQ [$];
  reg  [16:0] lfsrQ = 17'd84378;
  wire [7:0]  regRdata;
  wire [3:0]  portParFlag;
  wire [1:0]  cameraOutState;
  wire        i2cMasterEn, parityCheckEn, refClockPresent;
  integer     fails = 0, nTests = 0, i, k;
  hgcs_top i_hgcs_top (.ref_clk, .nrst, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata, .portLock, .portAssigned, .portParErr,
    .portErrClear, .portParFlag, .referenceClockInput(refIn),
    .configSumPassedIn(sumOk), .initDoneIn(initDone), .i2cMasterEn,
    .parityCheckEn, .cameraOutState, .refClockPresent);
  always #4 ref_clk = ~ref_clk;
  // About 25 MHz, free of the bank clock phase
  always #19.7 if (refRun) refIn = ~refIn;
  function [16:0] lfsrNext(input [16:0] s);
    lfsrNext = {s[15:0], s[16] ^ s[13]};
  endfunction
  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] s);
    begin
      nTests = nTests + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk); regAddr = a; regWdata = d; regWrite = 1;
      @(negedge ref_clk); regWrite = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge ref_clk); regAddr = a; regRead = 1; expQ.push_back(e);
      @(negedge ref_clk); regRead = 0;
    end
  endtask
  task pulse(input [3:0] m, input clr);
    begin
      @(negedge ref_clk); portParErr = clr ? 4'h0 : m; portErrClear = clr ? m : 4'h0;
      @(negedge ref_clk); portParErr = 0; portErrClear = 0;
    end
  endtask
  task closeOut;
    begin
      $display("checks %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk) rdLate <= regRead;
  always @(negedge ref_clk) if (rdLate) chk("regRdata", expQ.pop_front(), regRdata);
  initial begin
    #100000 fails = fails + 1;
    closeOut;
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    nrst = 1;
    rd(8'h02, 8'h1e);
    rd(8'h05, 8'h01);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    repeat (2100) @(negedge ref_clk);
    rd(8'h04, 8'hd0);
    refRun = 0;
    sumOk = 0;
    repeat (2100) @(negedge ref_clk);
    rd(8'h04, 8'h40);
    chk("refPres", refClockPresent, 8'h00);
    wr(8'h02, 8'h1f);
    chk("refPres", refClockPresent, 8'h01);
    for (i = 0; i < 16; i = i + 1) begin
      lfsrQ = lfsrNext(lfsrQ);
      v = {lfsrQ[7:5], i[2:0], lfsrQ[1:0]};
      wr(8'h02, v);
      wr(8'h03, ~v);
      rd(8'h03, 8'h00);
      rd(8'h02, v & 8'h3f);
      chk("i2cEn", i2cMasterEn, v[5]);
      chk("parEn", parityCheckEn, v[1]);
      portLock = lfsrQ[11:8];
      portAssigned = i[3] ? portLock : ~portLock;
      st = (portLock & portAssigned) != 0 ? 2'h0 : !v[4] ? 2'h1 :
           !v[2] ? 2'h3 : !v[3] ? 2'h1 : 2'h2;
      #1 chk("outState", cameraOutState, st);
    end
    wr(8'h02, 8'h1e);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h03);
    pulse(4'hf, 1);
    for (k = 0; k < 4; k = k + 1) pulse(4'hf << k, 0);
    repeat (3) @(negedge ref_clk);
    chk("parFlag", portParFlag, 8'h0c);
    wr(8'h05, 8'h01);
    repeat (3) @(negedge ref_clk);
    chk("parFlag", portParFlag, 8'h00);
    wr(8'h02, 8'h1c);
    wr(8'h05, 8'h00);
    pulse(4'hf, 1);
    for (k = 0; k < 4; k = k + 1) pulse(4'hf, 0);
    repeat (3) @(negedge ref_clk);
    chk("parFlag", portParFlag, 8'h00);
    closeOut;
  end
endmodule // hgcs_top_bench
`default_nettype wire
